// File: ccr_pkg.sv
// register map, reset values and state carrier for the converter configuration bank
package ccr_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [6:0] CCR_IDX_SYSREF_EDGE_POSITION = 7'h2C;
  localparam logic [6:0] CCR_IDX_FS_A = 7'h30;
  localparam logic [6:0] CCR_IDX_FS_B = 7'h32;
  localparam logic [6:0] CCR_IDX_REF_BYPASS = 7'h38;
  localparam logic [6:0] CCR_IDX_TSTAMP = 7'h3B;
  localparam logic [6:0] CCR_IDX_PREEMPH = 7'h48;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CCR_BIT_REF_BYPASS = 0;
  localparam int CCR_BIT_TS_RECV_EN = 0;
  localparam int CCR_BIT_TS_LVPECL = 1;
  localparam int CCR_POS_WIDTH = 24;
  localparam int CCR_FS_WIDTH = 16;
  localparam int CCR_PE_WIDTH = 4;

  // ----------------------------------------------------------------
  // full-scale codes and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CCR_FS_CODE_MIN = 16'h2000;
  localparam logic [15:0] CCR_FS_CODE_DEFAULT = 16'hA000;
  localparam logic [15:0] CCR_FS_CODE_MAX = 16'hFFFF;
  localparam logic [15:0] CCR_FS_RESET = CCR_FS_CODE_DEFAULT;
  localparam logic CCR_BIT_RESET = 1'h0;
  localparam logic [3:0] CCR_PE_RESET = 4'h0;
  localparam logic [31:0] CCR_RDATA_RESET = 32'h0000_0000;

  // ----------------------------------------------------------------
  // state carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] pos_sync1;
    logic [23:0] pos_sync2;
    logic [15:0] fs_a;
    logic [15:0] fs_b;
    logic ref_bypass;
    logic ts_lvpecl;
    logic ts_recv_en;
    logic [3:0] preemph;
    logic wr_pend;
    logic [6:0] wr_idx;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } ccr_state_t;

endpackage

// File: ccr_config_registers.sv
// converter configuration register bank behind an AHB-Lite slave port
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [RL1] 24-bit read-only SYSREF edge position status
// [RL2] software picks delay select from status
// [RL3] channel A full-scale range, resets 0xA000
// [RL4] codes 0x2000/0xA000/0xFFFF give 500/800/1000 mVPP
// [RL5] software keeps range codes at or above 0x2000
// [RL6] separate channel B full-scale range, same mapping
// [RL7] bypass bit selects supply as reference
// [RL8] timestamp bit 1 selects LVPECL mode
// [RL9] timestamp bit 0 enables the receiver
// [RL10] edge position status undefined after reset
// [RL11] unused control bits read zero, writes ignored
module ccr_config_registers
  import ccr_pkg::*;
(
  input wire logic clk, // 250 MHz register clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low except while reset_n is low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // response, always okay
  input wire logic [23:0] sysref_edge_position, // edge position from the detector
  output logic [15:0] fullscale_range_chan_a, // channel A range code
  output logic [15:0] fullscale_range_chan_b, // channel B range code
  output logic reference_bypass, // use supply as reference
  output logic timestamp_lvpecl_mode, // timestamp input in LVPECL mode
  output logic timestamp_receiver_enable, // timestamp receiver on
  output logic [3:0] serializer_preemphasis // pre-emphasis control bits
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ccr_state_t state;
  ccr_state_t next_state;
  logic addr_hit;
  logic xfer;

  function automatic logic [31:0] read_mux(input ccr_state_t st, input logic [6:0] idx);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (idx)
      // [RL1] status word in low bits
      CCR_IDX_SYSREF_EDGE_POSITION: v[23:0] = st.pos_sync2;
      CCR_IDX_FS_A: v[15:0] = st.fs_a;
      CCR_IDX_FS_B: v[15:0] = st.fs_b;
      // [RL11] only live bits returned
      CCR_IDX_REF_BYPASS: v[CCR_BIT_REF_BYPASS] = st.ref_bypass;
      CCR_IDX_TSTAMP:
      begin
        v[CCR_BIT_TS_RECV_EN] = st.ts_recv_en;
        v[CCR_BIT_TS_LVPECL] = st.ts_lvpecl;
      end
      CCR_IDX_PREEMPH: v[3:0] = st.preemph;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  assign addr_hit = (haddr[31:9] == 23'h000000);
  assign xfer = hsel && hready && htrans[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    // edge position crosses in from the detector's timing; two flops
    next_state.pos_sync1 = sysref_edge_position;
    next_state.pos_sync2 = state.pos_sync1;
    if (state.wr_pend)
    begin
      case (state.wr_idx)
        // [RL3] channel A write
        CCR_IDX_FS_A: next_state.fs_a = hwdata[15:0];
        // [RL6] channel B write
        CCR_IDX_FS_B: next_state.fs_b = hwdata[15:0];
        // [RL7] bypass bit write
        CCR_IDX_REF_BYPASS: next_state.ref_bypass = hwdata[CCR_BIT_REF_BYPASS];
        CCR_IDX_TSTAMP:
        begin
          // [RL8] lvpecl mode bit
          next_state.ts_lvpecl = hwdata[CCR_BIT_TS_LVPECL];
          // [RL9] receiver enable bit
          next_state.ts_recv_en = hwdata[CCR_BIT_TS_RECV_EN];
        end
        // [RL11] upper bits dropped on write
        CCR_IDX_PREEMPH: next_state.preemph = hwdata[3:0];
        // status and unmapped words ignore writes
        default: next_state.wr_pend = 1'b0;
      endcase
    end
    next_state.wr_pend = 1'b0;
    if (xfer)
    begin
      next_state.wr_pend = hwrite && addr_hit;
      next_state.wr_idx = haddr[8:2];
      // read from the updated copy so a write just finished is seen
      next_state.rdata = (!hwrite && addr_hit) ? read_mux(next_state, haddr[8:2])
                                               : CCR_RDATA_RESET;
    end
    next_state.ready = 1'b1;
    next_state.resp = 1'b0;
    if (!reset_n)
    begin
      // [RL3] [RL4] range codes start at the 800 mVPP default
      next_state.fs_a = CCR_FS_RESET;
      next_state.fs_b = CCR_FS_RESET;
      next_state.ref_bypass = CCR_BIT_RESET;
      next_state.ts_lvpecl = CCR_BIT_RESET;
      next_state.ts_recv_en = CCR_BIT_RESET;
      next_state.preemph = CCR_PE_RESET;
      next_state.wr_pend = 1'b0;
      next_state.wr_idx = 7'h00;
      next_state.rdata = CCR_RDATA_RESET;
      // [RL10] status flops left unreset, value undefined
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce || !reset_n)
    begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign hrdata = state.rdata;
  assign hreadyout = state.ready;
  assign hresp = state.resp;
  assign fullscale_range_chan_a = state.fs_a;
  assign fullscale_range_chan_b = state.fs_b;
  assign reference_bypass = state.ref_bypass;
  assign timestamp_lvpecl_mode = state.ts_lvpecl;
  assign timestamp_receiver_enable = state.ts_recv_en;
  assign serializer_preemphasis = state.preemph;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_fsa_reset_value: assert property ( // RL3
    @(posedge clk) $rose(reset_n) |-> fullscale_range_chan_a == CCR_FS_CODE_DEFAULT)
    else $error("channel A range not at default after reset");

  a_fsb_reset_value: assert property ( // RL4
    @(posedge clk) $rose(reset_n) |-> fullscale_range_chan_b == 16'hA000)
    else $error("channel B range not 800 mVPP code after reset");

  a_fsa_write_lands: assert property ( // RL3
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite && addr_hit && haddr[8:2] == CCR_IDX_FS_A) ##1 ce
    |=> fullscale_range_chan_a == $past(hwdata[15:0]))
    else $error("channel A range write lost");

  a_fsb_write_lands: assert property ( // RL6
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite && addr_hit && haddr[8:2] == CCR_IDX_FS_B) ##1 ce
    |=> fullscale_range_chan_b == $past(hwdata[15:0]) && $stable(fullscale_range_chan_a))
    else $error("channel B range write wrong");

  a_bypass_write_lands: assert property ( // RL7
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite && addr_hit && haddr[8:2] == CCR_IDX_REF_BYPASS) ##1 ce
    |=> reference_bypass == $past(hwdata[0]))
    else $error("reference bypass write lost");

  a_lvpecl_write_lands: assert property ( // RL8
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite && addr_hit && haddr[8:2] == CCR_IDX_TSTAMP) ##1 ce
    |=> timestamp_lvpecl_mode == $past(hwdata[1]))
    else $error("timestamp lvpecl write lost");

  a_recv_write_lands: assert property ( // RL9
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite && addr_hit && haddr[8:2] == CCR_IDX_TSTAMP) ##1 ce
    |=> timestamp_receiver_enable == $past(hwdata[0]))
    else $error("timestamp receiver enable write lost");

  a_status_read_value: assert property ( // RL1
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && !hwrite && addr_hit && haddr[8:2] == CCR_IDX_SYSREF_EDGE_POSITION)
    |=> hrdata == {8'h00, $past(state.pos_sync1)})
    else $error("edge position status read wrong");

  a_ctrl_upper_zero: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && !hwrite && addr_hit && haddr[8:2] == CCR_IDX_REF_BYPASS)
    |=> hrdata[31:1] == 31'h0000_0000 && hrdata[0] == $past(reference_bypass))
    else $error("bypass register upper bits not zero");

  // ----------------------------------------------------------------
  // bus response checks
  // ----------------------------------------------------------------
  a_ready_always_high: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    1'b1
    |-> hreadyout == 1'b1)
    else $error("slave ready dropped");

  a_resp_always_okay: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    1'b1
    |-> hresp == 1'b0)
    else $error("slave response not okay");

  a_write_reads_zero: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite)
    |=> hrdata == 32'h0000_0000)
    else $error("read data not cleared by write");

  a_unmapped_read_zero: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && !hwrite && !addr_hit)
    |=> hrdata == 32'h0000_0000)
    else $error("out of range read not zero");

  a_refused_write_kept: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite && !addr_hit) ##1 ce
    |=> $stable(fullscale_range_chan_a) && $stable(fullscale_range_chan_b))
    else $error("out of range write changed a range");

  a_pend_clears_idle: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    (ce && !xfer)
    |=> !state.wr_pend)
    else $error("write pending without transfer");

  // ----------------------------------------------------------------
  // read path and write checks
  // ----------------------------------------------------------------
  a_range_a_read: assert property ( // RL3
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && !hwrite && addr_hit && haddr[8:2] == CCR_IDX_FS_A && !state.wr_pend)
    |=> hrdata == {16'h0000, $past(fullscale_range_chan_a)})
    else $error("channel A range read wrong");

  a_range_b_read: assert property ( // RL6
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && !hwrite && addr_hit && haddr[8:2] == CCR_IDX_FS_B && !state.wr_pend)
    |=> hrdata == {16'h0000, $past(fullscale_range_chan_b)})
    else $error("channel B range read wrong");

  a_tstamp_read: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && !hwrite && addr_hit && haddr[8:2] == CCR_IDX_TSTAMP && !state.wr_pend)
    |=> hrdata == {30'h0000_0000, $past(timestamp_lvpecl_mode), $past(timestamp_receiver_enable)})
    else $error("timestamp control read wrong");

  a_preemph_read: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && !hwrite && addr_hit && haddr[8:2] == CCR_IDX_PREEMPH && !state.wr_pend)
    |=> hrdata == {28'h000_0000, $past(serializer_preemphasis)})
    else $error("pre-emphasis read wrong");

  a_preemph_write_lands: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite && addr_hit && haddr[8:2] == CCR_IDX_PREEMPH) ##1 ce
    |=> serializer_preemphasis == $past(hwdata[3:0]))
    else $error("pre-emphasis write lost");

  a_status_write_ignored: assert property ( // RL1
    @(posedge clk) disable iff (!reset_n)
    (ce && xfer && hwrite && addr_hit && haddr[8:2] == CCR_IDX_SYSREF_EDGE_POSITION) ##1 ce
    |=> $stable(fullscale_range_chan_a) && $stable(serializer_preemphasis))
    else $error("status write touched a setting");

  // ----------------------------------------------------------------
  // synchroniser, freeze, idle hold and reset checks
  // ----------------------------------------------------------------
  a_pos_first_stage: assert property ( // RL1
    @(posedge clk) disable iff (!reset_n)
    ce
    |=> state.pos_sync1 == $past(sysref_edge_position))
    else $error("edge position first stage wrong");

  a_pos_second_stage: assert property ( // RL1
    @(posedge clk) disable iff (!reset_n)
    ce
    |=> state.pos_sync2 == $past(state.pos_sync1))
    else $error("edge position second stage wrong");

  a_frozen_range_a: assert property ( // RL3
    @(posedge clk) disable iff (!reset_n)
    !ce
    |=> $stable(fullscale_range_chan_a) && $stable(fullscale_range_chan_b))
    else $error("range changed while frozen");

  a_frozen_rdata: assert property ( // RL11
    @(posedge clk) disable iff (!reset_n)
    !ce
    |=> $stable(hrdata) && $stable(serializer_preemphasis))
    else $error("read data changed while frozen");

  a_frozen_ctrl_bits: assert property ( // RL7
    @(posedge clk) disable iff (!reset_n)
    !ce
    |=> $stable(reference_bypass) && $stable(timestamp_receiver_enable))
    else $error("control bit changed while frozen");

  a_ranges_hold_idle: assert property ( // RL6
    @(posedge clk) disable iff (!reset_n)
    (ce && !state.wr_pend)
    |=> $stable(fullscale_range_chan_a) && $stable(fullscale_range_chan_b))
    else $error("range changed without a write");

  a_ctrl_reset_zero: assert property ( // RL11
    @(posedge clk)
    $rose(reset_n)
    |-> !reference_bypass && !timestamp_lvpecl_mode && !timestamp_receiver_enable)
    else $error("control bits not zero after reset");

  a_bus_reset_state: assert property ( // RL11
    @(posedge clk)
    $rose(reset_n)
    |-> hrdata == CCR_RDATA_RESET && serializer_preemphasis == CCR_PE_RESET)
    else $error("bus state not reset");

endmodule
`default_nettype wire

// File: ccr_config_registers_test.sv
// self-checking bench for the converter configuration register bank
`timescale 1ns/1ps
`default_nettype none
module ccr_config_registers_test
  import ccr_pkg::*;
;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [23:0] sysref_edge_position = 24'h0;
  logic [15:0] fs_a, fs_b;
  logic bypass, lvpecl, recv_en;
  logic [3:0] preemph;
  logic [31:0] seed = 32'h8AC2;
  logic [31:0] rd;
  int fails = 0;
  int tests_run = 0;
  int model[int];
  int mask[int];
  always #2 clk = ~clk;
  ccr_config_registers dut_u (.clk(clk), .reset_n(reset_n), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .sysref_edge_position(sysref_edge_position), .fullscale_range_chan_a(fs_a),
    .fullscale_range_chan_b(fs_b), .reference_bypass(bypass),
    .timestamp_lvpecl_mode(lvpecl), .timestamp_receiver_enable(recv_en),
    .serializer_preemphasis(preemph));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single transfer; waits on hready, never on a fixed count
  task automatic xfer(input logic w, input int idx, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= 32'(idx) << 2;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) fails++;
    htrans <= 2'h0;
    hwdata <= wd;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) fails++;
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (w && ce === 1'b1 && mask.exists(idx))
      model[idx] = wd & mask[idx];
  endtask
  task automatic rd_chk(input string what, input int idx);
    xfer(1'b0, idx, xs());
    chk(what, model.exists(idx) ? model[idx] : 32'h0, rd);
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    model.delete();
    model['h30] = 'hA000;
    model['h32] = 'hA000;
    model['h38] = 0;
    model['h3B] = 0;
    model['h48] = 0;
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #40000;
    fails++;
    results();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [15:0] codes[4];
    logic [31:0] v;
    mask['h30] = 'hFFFF;
    mask['h32] = 'hFFFF;
    mask['h38] = 'h1;
    mask['h3B] = 'h3;
    mask['h48] = 'hF;
    codes = '{16'h2000, 16'hA000, 16'hFFFF, 16'h5A5A};
    do_reset();
    foreach (mask[i]) rd_chk("reset value", i);
    $display("test reset values done");
    repeat (3)
    begin
      v = xs();
      sysref_edge_position <= v[23:0];
      repeat (4) @(posedge clk);
      xfer(1'b1, 'h2C, 32'hFFFF_FFFF);
      xfer(1'b0, 'h2C, 32'h0);
      chk("edge position", {8'h0, sysref_edge_position}, rd);
    end
    $display("test edge position done");
    // range codes pass unchanged per channel
    foreach (codes[i])
    begin
      v = xs();
      xfer(1'b1, 'h30, {v[31:16], codes[i]});
      xfer(1'b1, 'h32, {16'h0, codes[3 - i]});
      rd_chk("range a", 'h30);
      rd_chk("range b", 'h32);
      chk("range a pin", model['h30], {16'h0, fs_a});
      chk("range b pin", model['h32], {16'h0, fs_b});
    end
    $display("test range codes done");
    repeat (6)
    begin
      xfer(1'b1, 'h38, xs());
      xfer(1'b1, 'h3B, xs());
      xfer(1'b1, 'h48, xs());
      rd_chk("bypass", 'h38);
      rd_chk("timestamp", 'h3B);
      rd_chk("preemphasis", 'h48);
      chk("bypass pin", model['h38], {31'h0, bypass});
      chk("lvpecl pin", model['h3B] >> 1, {31'h0, lvpecl});
      chk("recv pin", model['h3B] & 1, {31'h0, recv_en});
      chk("preemph pin", model['h48], {28'h0, preemph});
    end
    $display("test control bits done");
    xfer(1'b1, 'h31, 32'hFFFF_FFFF);
    rd_chk("unmapped", 'h31);
    xfer(1'b1, 'h830, 32'hFFFF_FFFF);
    rd_chk("out of range", 'h830);
    rd_chk("range a kept", 'h30);
    ce <= 1'b0;
    xfer(1'b1, 'h30, 32'h0000_5555);
    ce <= 1'b1;
    rd_chk("frozen write", 'h30);
    $display("test refused accesses done");
    do_reset();
    @(posedge clk);
    chk("range a after reset", 32'hA000, {16'h0, fs_a});
    rd_chk("range b after reset", 'h32);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
